// [verilog/fpu_exception_status_control.sv]
// exception flags, masks, condition codes, mode control and error pointers
//
// Contract
// (RL1) on each instruction start capture instruction address, operand address and opcode
// (RL2) real mode pointers are 20-bit physical addresses plus an 11-bit opcode
// (RL3) protected mode pointers are the full 32-bit virtual addresses
// (RL4) captured instruction address points at the first prefix byte
// (RL5) compare and test set C3,C2,C0 from the relation, C1 untouched
// (RL6) remainder: complete gives C2=0 and quotient bits, incomplete gives C2=1
// (RL7) examine encodes operand class in four condition bits, C1 is sign
// (RL8) examine reports zero-exponent invalid operands as 1100 or 1110
// (RL9) control bits 5..0 mask the six exceptions
// (RL10) control bits 9..8 select precision, default extended
// (RL11) control bits 11..10 select rounding mode
// (RL12) control bit 12 selects affine or projective infinity
// (RL13) error output asserts when an unmasked exception occurs
// (RL14) stack faults, indeterminate forms and NaN operands raise invalid
// (RL15) NaN means all-ones exponent with nonzero significand
// (RL16) too-large result raises overflow, finite/zero raises zero-divide
// (RL17) too-small nonzero result raises underflow, masked means gradual underflow
// (RL18) smallest exponent with nonzero significand raises denormal operand
// (RL19) unrepresentable exact result raises inexact, masked continues
// (RL20) unmasked exception sets its flag, the summary bit and error output
// (RL21) host traps escape or wait while an unmasked error is pending
// (RL22) on error the faulting instruction and operand addresses are retained
// (RL23) status bit 7 is the summary of unmasked flags and drives error
// (RL24) status bits 5..0 hold the six exception flags
// (RL25) flags stay set until software clears them
`timescale 1ns/1ps
`default_nettype none

module fpu_exception_status_control
	import fpu_exc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire instr_start_t start_i,
	input wire exec_report_t rep_i,
	output logic error_o,
	output var resp_t resp_o,
	output logic [3:0] cc_o,
	output logic [1:0] prec_o,
	output var round_mode_t round_o,
	output logic affine_o
);

	function automatic opclass_t classify(input logic [79:0] v);
		if (v[78:64] == EXP_MAX) begin
			return (v[62:0] == 63'h0) ? CLS_INF : CLS_NAN; // RL15
		end else if (v[78:64] == 15'h0000) begin
			return (v[63:0] == 64'h0) ? CLS_ZERO : CLS_DENORM;
		end else begin
			return v[63] ? CLS_NORM : CLS_UNNORM;
		end
	endfunction

	// {C3,C2,C1,C0}; C1 always carries the sign
	function automatic logic [3:0] exam_code(input opclass_t c, input logic s,
			input logic empty);
		if (empty) begin
			return {2'b10, s, 1'b1}; // RL7
		end
		case (c)
			CLS_NORM: return {2'b01, s, 1'b0}; // RL7
			CLS_UNNORM: return {2'b00, s, 1'b0};
			CLS_INF: return {2'b01, s, 1'b1};
			CLS_ZERO: return {2'b10, s, 1'b0};
			CLS_DENORM: return {2'b11, s, 1'b0}; // RL8
			default: return {2'b00, s, 1'b1}; // RL7
		endcase
	endfunction

	function automatic logic [31:0] ptr_fmt(input logic [31:0] a, input logic prot);
		return prot ? a : {REAL_ADDR_PAD, a[19:0]}; // RL2 RL3
	endfunction

	function automatic resp_t pick_resp(input logic [5:0] ex, input logic [5:0] msk,
			input logic nan_in);
		if (|(ex & ~msk)) begin
			return RESP_TRAP;
		end else if (ex[EXC_INV]) begin
			return nan_in ? RESP_NAN_PROP : RESP_NAN_DEF; // RL14
		end else if (ex[EXC_ZDIV] | ex[EXC_OVF]) begin
			return RESP_INF; // RL16
		end else if (ex[EXC_UNF]) begin
			return RESP_DENORM; // RL17
		end else begin
			return RESP_CONT; // RL18 RL19
		end
	endfunction

	state_t s_q;
	state_t s_d;
	opclass_t cls_a;
	opclass_t cls_b;
	logic [5:0] det;
	logic [5:0] clr;
	logic [15:0] ctrl_w;
	logic [31:0] rd;
	logic hit;
	logic wr_en;
	logic rd_en;
	logic arith;
	logic nan_in;

	always_comb begin
		s_d = s_q;
		cls_a = classify(rep_i.op_a);
		cls_b = classify(rep_i.op_b);
		det = 6'h00;
		clr = 6'h00;
		ctrl_w = s_q.ctrl;
		rd = 32'h0000_0000;
		hit = 1'b1;
		// one wait state: answer lands on the second access cycle
		rd_en = psel_i & penable_i & ~s_q.pready;
		wr_en = psel_i & penable_i & s_q.pready & pwrite_i;
		arith = rep_i.valid & (rep_i.kind != CC_EXAM);
		nan_in = (cls_a == CLS_NAN) | (rep_i.div_op & (cls_b == CLS_NAN));

		if (paddr_i[ADDR_W-1:0] == OFF_CTRL) begin
			rd = {16'h0000, s_q.ctrl};
		end else if (paddr_i[ADDR_W-1:0] == OFF_STATUS) begin
			rd = {16'h0000, 1'b0, s_q.cc[3], 3'b000, s_q.cc[2:0], s_q.es, 1'b0,
				s_q.flags}; // RL23 RL24
		end else if (paddr_i[ADDR_W-1:0] == OFF_IPTR) begin
			rd = s_q.ip;
		end else if (paddr_i[ADDR_W-1:0] == OFF_DPTR) begin
			rd = s_q.dp;
		end else if (paddr_i[ADDR_W-1:0] == OFF_OPCODE) begin
			rd = {20'h0_0000, s_q.prot, s_q.opc};
		end else begin
			hit = 1'b0;
		end

		s_d.pready = rd_en;
		if (rd_en) begin
			s_d.prdata = pwrite_i ? 32'h0000_0000 : rd;
			s_d.pslverr = ~hit;
		end

		// byte lanes honoured; reserved control bits never stick
		if (wr_en && paddr_i[ADDR_W-1:0] == OFF_CTRL) begin
			if (pstrb_i[0]) begin
				ctrl_w[7:0] = pwdata_i[7:0]; // RL9
			end
			if (pstrb_i[1]) begin
				ctrl_w[15:8] = pwdata_i[15:8]; // RL10 RL11 RL12
			end
		end
		s_d.ctrl = ctrl_w & CTRL_WMASK;

		// write one to clear; a flag raised in the same cycle survives
		if (wr_en && paddr_i[ADDR_W-1:0] == OFF_STATUS && pstrb_i[0]) begin
			clr = pwdata_i[5:0]; // RL25
		end

		if (arith) begin
			det[EXC_INV] = rep_i.stack_fault | rep_i.indeterminate | nan_in; // RL14
			det[EXC_DEN] = (cls_a == CLS_DENORM) |
				(rep_i.div_op & (cls_b == CLS_DENORM)); // RL18
			det[EXC_ZDIV] = rep_i.div_op & (cls_b == CLS_ZERO) &
				(cls_a != CLS_ZERO) & (cls_a != CLS_INF) & (cls_a != CLS_NAN); // RL16
			det[EXC_OVF] = rep_i.too_large; // RL16
			det[EXC_UNF] = rep_i.too_small & rep_i.res_nonzero; // RL17
			det[EXC_PREC] = rep_i.not_exact; // RL19
		end
		s_d.flags = (s_q.flags & ~clr) | det; // RL24 RL25 RL20
		s_d.es = |(s_d.flags & ~s_d.ctrl[5:0]); // RL13 RL20 RL23

		if (rep_i.valid) begin
			s_d.resp = pick_resp(det, s_q.ctrl[5:0], nan_in); // RL9
		end

		if (rep_i.valid) begin
			case (rep_i.kind)
				CC_CMP: begin
					case (rep_i.rel)
						REL_GT: {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'b000; // RL5
						REL_LT: {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'b001;
						REL_EQ: {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'b100;
						default: {s_d.cc[3], s_d.cc[2], s_d.cc[0]} = 3'b111;
					endcase
				end
				CC_REM: begin
					// incomplete reduction leaves the undefined bits as they were
					s_d.cc[2] = ~rep_i.rem_done; // RL6
					if (rep_i.rem_done) begin
						s_d.cc[3] = rep_i.quot[1]; // RL6
						s_d.cc[1] = rep_i.quot[0];
						s_d.cc[0] = rep_i.quot[2];
					end
				end
				CC_EXAM: begin
					s_d.cc = exam_code(cls_a, rep_i.op_a[79], rep_i.top_empty); // RL7 RL8
				end
				default: begin
				end
			endcase
		end

		// pending error freezes the pointers of the faulting instruction
		if (start_i.valid && !s_q.es) begin
			s_d.prot = start_i.prot;
			s_d.ip = ptr_fmt(start_i.esc_addr - 32'(start_i.prefix_cnt),
				start_i.prot); // RL1 RL4 RL22
			if (start_i.has_opnd) begin
				s_d.dp = ptr_fmt(start_i.opnd_addr, start_i.prot); // RL1 RL3
			end else begin
				s_d.dp = ptr_fmt(s_q.dp, start_i.prot);
			end
			// protected format holds no opcode
			s_d.opc = start_i.prot ? 11'h000 : start_i.opcode; // RL2
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '{ctrl: CTRL_RESET, resp: RESP_NONE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata_o = s_q.prdata;
	assign pready_o = s_q.pready;
	assign pslverr_o = s_q.pslverr;
	assign error_o = s_q.es;
	assign resp_o = s_q.resp;
	assign cc_o = s_q.cc;
	assign prec_o = s_q.ctrl[CTRL_PREC_LO+:2];
	assign round_o = round_mode_t'(s_q.ctrl[CTRL_RND_LO+:2]);
	assign affine_o = s_q.ctrl[CTRL_INF_BIT];

	// checking helpers
	logic [31:0] ip_want;
	logic new_ptr;
	assign ip_want = ptr_fmt(start_i.esc_addr - 32'(start_i.prefix_cnt), start_i.prot);
	assign new_ptr = start_i.valid & ~s_q.es;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_setup;
		psel_i & ~penable_i;
	endsequence

	sequence s_ctrl_wr;
		psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0] &
			(paddr_i[ADDR_W-1:0] == OFF_CTRL);
	endsequence

	sequence s_cmp_eq;
		rep_i.valid & (rep_i.kind == CC_CMP) & (rep_i.rel == REL_EQ);
	endsequence

	property p_apb_answer;
		s_setup ##1 psel_i & penable_i |-> !pready_o ##1 pready_o;
	endproperty
	a_apb_answer: assert property (p_apb_answer)
		else $error("apb answer not on second access cycle");

	property p_cap_ip;
		new_ptr |=> s_q.ip == $past(ip_want);
	endproperty
	a_cap_ip: assert property (p_cap_ip) // RL1
		else $error("instruction pointer not captured");

	property p_prefix;
		new_ptr & start_i.prot |=>
			s_q.ip + 32'($past(start_i.prefix_cnt)) == $past(start_i.esc_addr);
	endproperty
	a_prefix: assert property (p_prefix) // RL4
		else $error("instruction pointer does not reach first prefix");

	property p_real_fmt;
		!s_q.prot |-> (s_q.ip[31:20] == 12'h000) && (s_q.dp[31:20] == 12'h000);
	endproperty
	a_real_fmt: assert property (p_real_fmt) // RL2
		else $error("real mode pointer wider than 20 bits");

	property p_prot_dp;
		new_ptr & start_i.prot & start_i.has_opnd |=>
			s_q.dp == $past(start_i.opnd_addr) && s_q.opc == 11'h000;
	endproperty
	a_prot_dp: assert property (p_prot_dp) // RL3
		else $error("protected operand pointer wrong");

	property p_hold_ptr;
		s_q.es |=> $stable(s_q.ip) && $stable(s_q.dp);
	endproperty
	a_hold_ptr: assert property (p_hold_ptr) // RL22
		else $error("pointers changed while error pending");

	property p_cmp_eq;
		s_cmp_eq |=> s_q.cc[3:2] == 2'b10 && !s_q.cc[0] && s_q.cc[1] == $past(s_q.cc[1]);
	endproperty
	a_cmp_eq: assert property (p_cmp_eq) // RL5
		else $error("compare equal code wrong");

	property p_rem;
		rep_i.valid & (rep_i.kind == CC_REM) & rep_i.rem_done |=>
			s_q.cc == {$past(rep_i.quot[1]), 1'b0, $past(rep_i.quot[0]),
				$past(rep_i.quot[2])};
	endproperty
	a_rem: assert property (p_rem) // RL6
		else $error("remainder quotient code wrong");

	property p_exam_empty;
		rep_i.valid & (rep_i.kind == CC_EXAM) & rep_i.top_empty |=>
			s_q.cc[3] && !s_q.cc[2] && s_q.cc[0] && s_q.cc[1] == $past(rep_i.op_a[79]);
	endproperty
	a_exam_empty: assert property (p_exam_empty) // RL7
		else $error("examine empty code wrong");

	// both signs: the bench only ever examines a negative zero-exponent operand
	property p_exam_den;
		rep_i.valid & (rep_i.kind == CC_EXAM) & !rep_i.top_empty &
			(rep_i.op_a[78:64] == 15'h0000) & (rep_i.op_a[63:0] != 64'h0) |=>
			s_q.cc == {2'b11, $past(rep_i.op_a[79]), 1'b0};
	endproperty
	a_exam_den: assert property (p_exam_den) // RL8
		else $error("examine zero exponent code wrong");

	property p_mask_wr;
		s_ctrl_wr |=> s_q.ctrl[5:0] == $past(pwdata_i[5:0]);
	endproperty
	a_mask_wr: assert property (p_mask_wr) // RL9
		else $error("mask bits not written");

	property p_error;
		error_o == |(s_q.flags & ~s_q.ctrl[5:0]);
	endproperty
	a_error: assert property (p_error) // RL13 RL23
		else $error("error output disagrees with unmasked flags");

	property p_nan;
		rep_i.valid & (rep_i.kind != CC_EXAM) & (rep_i.op_a[78:64] == EXP_MAX) &
			(rep_i.op_a[62:0] != 63'h0) |=> s_q.flags[EXC_INV];
	endproperty
	a_nan: assert property (p_nan) // RL15
		else $error("nan operand did not raise invalid");

	property p_unmasked;
		rep_i.valid & |(det & ~s_q.ctrl[5:0]) |=> error_o && resp_o == RESP_TRAP;
	endproperty
	a_unmasked: assert property (p_unmasked) // RL20
		else $error("unmasked exception not signalled");

	property p_sticky;
		!(psel_i & penable_i & pwrite_i & (paddr_i[ADDR_W-1:0] == OFF_STATUS)) |=>
			(s_q.flags & $past(s_q.flags)) == $past(s_q.flags);
	endproperty
	a_sticky: assert property (p_sticky) // RL25
		else $error("flag dropped without software clear");

endmodule

`default_nettype wire

// [verilog/fpu_exc_pkg.sv]
// constants, register map and carrier types of the exception and status unit
package fpu_exc_pkg;
	// apb register byte offsets
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IPTR = 8'h08;
	localparam logic [7:0] OFF_DPTR = 8'h0C;
	localparam logic [7:0] OFF_OPCODE = 8'h10;

	// exception_mode_control layout and reset value
	localparam logic [15:0] CTRL_RESET = 16'h033F;
	localparam logic [15:0] CTRL_WMASK = 16'h1F3F;
	localparam int CTRL_PREC_LO = 8;
	localparam int CTRL_RND_LO = 10;
	localparam int CTRL_INF_BIT = 12;

	// exception flag and mask positions
	localparam int EXC_INV = 0;
	localparam int EXC_DEN = 1;
	localparam int EXC_ZDIV = 2;
	localparam int EXC_OVF = 3;
	localparam int EXC_UNF = 4;
	localparam int EXC_PREC = 5;

	// status word and opcode register positions
	localparam int ST_ES = 7;
	localparam int ST_C0 = 8;
	localparam int ST_C1 = 9;
	localparam int ST_C2 = 10;
	localparam int ST_C3 = 14;
	localparam int OPC_PROT_BIT = 11;

	localparam logic [14:0] EXP_MAX = 15'h7FFF;
	localparam logic [11:0] REAL_ADDR_PAD = 12'h000;

	typedef enum logic [1:0] {
		CC_NONE = 2'b00,
		CC_CMP = 2'b01,
		CC_REM = 2'b10,
		CC_EXAM = 2'b11
	} cc_kind_t;

	typedef enum logic [1:0] {
		REL_GT = 2'b00,
		REL_LT = 2'b01,
		REL_EQ = 2'b10,
		REL_UNORD = 2'b11
	} rel_t;

	typedef enum logic [1:0] {
		RND_NEAR = 2'b00,
		RND_DOWN = 2'b01,
		RND_UP = 2'b10,
		RND_CHOP = 2'b11
	} round_mode_t;

	typedef enum logic [2:0] {
		RESP_NONE = 3'b000,
		RESP_NAN_DEF = 3'b001,
		RESP_NAN_PROP = 3'b010,
		RESP_INF = 3'b011,
		RESP_DENORM = 3'b100,
		RESP_CONT = 3'b101,
		RESP_TRAP = 3'b110
	} resp_t;

	typedef enum logic [2:0] {
		CLS_NORM = 3'b000,
		CLS_UNNORM = 3'b001,
		CLS_INF = 3'b010,
		CLS_ZERO = 3'b011,
		CLS_DENORM = 3'b100,
		CLS_NAN = 3'b101
	} opclass_t;

	typedef struct packed {
		logic valid;
		logic [31:0] esc_addr;
		logic [3:0] prefix_cnt;
		logic has_opnd;
		logic [31:0] opnd_addr;
		logic [10:0] opcode;
		logic prot;
	} instr_start_t;

	typedef struct packed {
		logic valid;
		cc_kind_t kind;
		logic stack_fault;
		logic indeterminate;
		logic div_op;
		logic too_large;
		logic too_small;
		logic res_nonzero;
		logic not_exact;
		rel_t rel;
		logic rem_done;
		logic [2:0] quot;
		logic top_empty;
		logic [79:0] op_a;
		logic [79:0] op_b;
	} exec_report_t;

	typedef struct packed {
		logic [15:0] ctrl;
		logic [5:0] flags;
		logic es;
		logic [3:0] cc;
		logic [31:0] ip;
		logic [31:0] dp;
		logic [10:0] opc;
		logic prot;
		resp_t resp;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_t;
endpackage

// [tb/host_model.sv]
// host side model: issues escape starts and finished-instruction reports
`timescale 1ns/1ps
`default_nettype none

module host_model
	import fpu_exc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic error_i,
	output var instr_start_t start_o,
	output var exec_report_t rep_o
);
	int traps = 0;

	initial begin
		start_o = '0;
		rep_o = '0;
	end

	// rogue set: a faulty host that ignores the pending error
	task automatic issue(input instr_start_t s, input logic rogue);
		@(posedge clk_sys_i);
		if (error_i === 1'b1 && rogue !== 1'b1) begin
			traps++;
			return;
		end
		start_o <= s;
		@(posedge clk_sys_i);
		start_o <= '0;
	endtask

	task automatic report(input exec_report_t r);
		@(posedge clk_sys_i);
		rep_o <= r;
		@(posedge clk_sys_i);
		rep_o <= '0;
	endtask
endmodule

`default_nettype wire

// [tb/fpu_exception_status_control_tb.sv]
// self-checking bench of the exception and status unit
`timescale 1ns/1ps
`default_nettype none

module fpu_exception_status_control_tb;
	import fpu_exc_pkg::*;

	localparam logic [79:0] ONE = 80'h3FFF_8000_0000_0000_0000;
	logic clk_sys_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [31:0] paddr_i = '0;
	logic [31:0] pwdata_i = '0;
	logic [3:0] pstrb_i = 4'hF;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	instr_start_t start_i;
	exec_report_t rep_i;
	logic error_o;
	resp_t resp_o;
	logic [3:0] cc_o;
	logic [1:0] prec_o;
	round_mode_t round_o;
	logic affine_o;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	exec_report_t r;
	logic [31:0] q;
	logic [31:0] ex;
	logic e;
	logic [1:0] m;
	logic [79:0] xa [8];
	logic [3:0] xc [8];
	logic [2:0] ct [4];
	resp_t xr [7];
	int xb [7];

	always #5 clk_sys_i = ~clk_sys_i;

	fpu_exception_status_control dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
		.pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .start_i(start_i), .rep_i(rep_i), .error_o(error_o),
		.resp_o(resp_o), .cc_o(cc_o), .prec_o(prec_o), .round_o(round_o), .affine_o(affine_o));

	host_model host (.clk_sys_i(clk_sys_i), .error_i(error_o), .start_o(start_i), .rep_o(rep_i));

	task automatic give_verdict();
		if (miscompares == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rq, output logic re);
		@(posedge clk_sys_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= {24'h00_0000, a};
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		do @(posedge clk_sys_i); while (pready_o !== 1'b1);
		rq = prdata_o;
		re = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
		logic [31:0] rq;
		logic re;
		apb(1'b0, a, 32'h0000_0000, rq, re);
		chk(rq & msk, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rq;
		logic re;
		apb(1'b1, a, d, rq, re);
		#1;
	endtask

	function automatic exec_report_t rp(input cc_kind_t k);
		rp = '0;
		rp.valid = 1'b1;
		rp.kind = k;
		rp.op_a = ONE;
		rp.op_b = ONE;
	endfunction

	initial begin
		xa = '{ONE, ONE, 80'h3FFF_4000_0000_0000_0000, 80'h7FFF_8000_0000_0000_0000,
			80'h8000_0000_0000_0000_0000, 80'h7FFF_C000_0000_0000_0000,
			80'h8000_0000_0000_0000_0001, 80'hBFFF_8000_0000_0000_0000};
		xc = '{4'h9, 4'h4, 4'h0, 4'h5, 4'hA, 4'h1, 4'hE, 4'h6};
		ct = '{3'b000, 3'b001, 3'b100, 3'b111};
		xr = '{RESP_NAN_DEF, RESP_NAN_PROP, RESP_CONT, RESP_INF, RESP_INF, RESP_DENORM, RESP_CONT};
		xb = '{0, 0, 1, 2, 3, 4, 5};
		repeat (4) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		rd(OFF_CTRL, 32'h0000_033F, 32'hFFFF_FFFF);
		rd(OFF_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
		chk({26'h000_0000, prec_o, round_o, affine_o, error_o}, 32'h0000_0030);
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			wr(OFF_CTRL, {16'hFFFF, 3'b111, m[0], m, ~m, 8'hFF});
			chk({26'h000_0000, prec_o, round_o, affine_o, 1'b0}, {26'h0, ~m, m, m[0], 1'b0});
			rd(OFF_CTRL, {19'h0, m[0], m, ~m, 8'h3F}, 32'hFFFF_FFFF);
		end
		// examine leaves a negative operand last so the sign bit is 1 for compares
		for (int k = 0; k < 8; k++) begin
			r = rp(CC_EXAM);
			r.op_a = xa[k];
			r.top_empty = (k == 0);
			host.report(r);
			#1 chk({28'h000_0000, cc_o}, {28'h000_0000, xc[k]});
		end
		for (int k = 0; k < 4; k++) begin
			r = rp(CC_CMP);
			r.rel = rel_t'(k);
			host.report(r);
			#1 chk({28'h0, cc_o}, {28'h0, ct[k][2:1], 1'b1, ct[k][0]});
		end
		r = rp(CC_REM);
		r.rem_done = 1'b1;
		r.quot = 3'b110;
		host.report(r);
		#1 chk({28'h000_0000, cc_o}, 32'h0000_0009);
		r.rem_done = 1'b0;
		host.report(r);
		#1 chk({28'h000_0000, cc_o}, 32'h0000_000D);
		ex = 32'h0000_0000;
		for (int k = 0; k < 7; k++) begin
			r = rp(CC_NONE);
			case (k)
				0: r.stack_fault = 1'b1;
				1: r.op_a = 80'h7FFF_8000_0000_0000_0001;
				2: r.op_a = 80'h0000_0000_0000_0000_0001;
				3: begin
					r.div_op = 1'b1;
					r.op_b = '0;
				end
				4: r.too_large = 1'b1;
				5: {r.too_small, r.res_nonzero} = 2'b11;
				default: r.not_exact = 1'b1;
			endcase
			host.report(r);
			#1 chk({29'h0, resp_o}, {29'h0, xr[k]});
			ex[xb[k]] = 1'b1;
			rd(OFF_STATUS, ex, 32'h0000_00FF);
		end
		wr(OFF_STATUS, 32'h0000_003F);
		rd(OFF_STATUS, 32'h0000_0000, 32'h0000_00FF);
		wr(OFF_CTRL, 32'h0000_0300);
		host.issue('{1'b1, 32'h0012_3458, 4'h2, 1'b1, 32'hABC1_2345, 11'h5A5, 1'b0}, 1'b0);
		rd(OFF_IPTR, 32'h0002_3456, 32'hFFFF_FFFF);
		rd(OFF_DPTR, 32'h0001_2345, 32'hFFFF_FFFF);
		rd(OFF_OPCODE, 32'h0000_05A5, 32'hFFFF_FFFF);
		host.issue('{1'b1, 32'h8765_4324, 4'h4, 1'b1, 32'hABC1_2345, 11'h5A5, 1'b1}, 1'b0);
		rd(OFF_IPTR, 32'h8765_4320, 32'hFFFF_FFFF);
		rd(OFF_DPTR, 32'hABC1_2345, 32'hFFFF_FFFF);
		rd(OFF_OPCODE, 32'h0000_0800, 32'hFFFF_FFFF);
		r = rp(CC_NONE);
		r.too_large = 1'b1;
		host.report(r);
		#1 chk({28'h0, resp_o, error_o}, {28'h0, RESP_TRAP, 1'b1});
		rd(OFF_STATUS, 32'h0000_0088, 32'h0000_00FF);
		host.issue('{1'b1, 32'h0000_1000, 4'h0, 1'b1, 32'h0000_2000, 11'h001, 1'b0}, 1'b0);
		chk(host.traps, 32'h0000_0001);
		host.issue('{1'b1, 32'h0000_1000, 4'h0, 1'b1, 32'h0000_2000, 11'h001, 1'b0}, 1'b1);
		rd(OFF_IPTR, 32'h8765_4320, 32'hFFFF_FFFF);
		rd(OFF_DPTR, 32'hABC1_2345, 32'hFFFF_FFFF);
		wr(OFF_CTRL, 32'h0000_0308);
		chk({31'h0, error_o}, 32'h0000_0000);
		rd(OFF_STATUS, 32'h0000_0008, 32'h0000_00FF);
		apb(1'b0, 8'h20, 32'h0000_0000, q, e);
		chk({q[30:0], e}, 32'h0000_0001);
		give_verdict();
	end
endmodule

`default_nettype wire
